// *** core/gain_stager.sv ***
`timescale 1ns/1ps
// Active gain of one amplifier, with optional zero-cross hold
module gain_stager import pga_regs_pkg::*; (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic reset_i,
    input wire logic clear_i,
    // Control
    input wire logic update_i,
    input wire logic zc_gate_i,
    input wire logic zero_cross_i,
    input wire logic timeout_i,
    input wire logic [GAIN_W-1:0] staged_i,
    // Result
    output logic [GAIN_W-1:0] active_o,
    output logic pending_o
);

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_WAIT = 2'b10
    } stage_state_t;

    stage_state_t state_r;
    stage_state_t state_nxt;
    logic [GAIN_W-1:0] active_r;
    logic [GAIN_W-1:0] active_nxt;
    logic [GAIN_W-1:0] hold_r;
    logic [GAIN_W-1:0] hold_nxt;

    // A fresh update while waiting replaces the held value, so the newest wins
    always_comb begin
        state_nxt = state_r;
        active_nxt = active_r;
        hold_nxt = hold_r;
        unique case (state_r)
            ST_IDLE: begin
                if (update_i && zc_gate_i) begin
                    hold_nxt = staged_i;
                    state_nxt = ST_WAIT;
                end else if (update_i) begin
                    active_nxt = staged_i;
                end
            end
            ST_WAIT: begin
                if (update_i && zc_gate_i) begin
                    hold_nxt = staged_i;
                end else if (update_i) begin
                    active_nxt = staged_i;
                    state_nxt = ST_IDLE;
                end else if (zero_cross_i || timeout_i || !zc_gate_i) begin
                    active_nxt = hold_r;
                    state_nxt = ST_IDLE;
                end
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
        if (clear_i) begin
            state_nxt = ST_IDLE;
            active_nxt = GAIN_RESET;
            hold_nxt = GAIN_RESET;
        end
    end

    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            state_r <= ST_IDLE;
            active_r <= GAIN_RESET;
            hold_r <= GAIN_RESET;
        end else begin
            state_r <= state_nxt;
            active_r <= active_nxt;
            hold_r <= hold_nxt;
        end
    end

    assign active_o = active_r;
    assign pending_o = (state_r == ST_WAIT);

    chk_immediate_apply: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        update_i && !zc_gate_i && !clear_i |=> active_r == $past(staged_i) && state_r == ST_IDLE)
        else $error("immediate update did not load gain");

    chk_hold_pending: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        state_r == ST_WAIT && !update_i && !zero_cross_i && !timeout_i && zc_gate_i && !clear_i
        |=> $stable(active_r) && state_r == ST_WAIT)
        else $error("pending gain applied without crossing or timeout");

    chk_release_held: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        state_r == ST_WAIT && !update_i && (zero_cross_i || timeout_i) && !clear_i
        |=> active_r == $past(hold_r) && state_r == ST_IDLE)
        else $error("held gain not applied on crossing or timeout");

    chk_no_update_stable: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        state_r == ST_IDLE && !update_i && !clear_i |=> $stable(active_r))
        else $error("active gain changed without update");

endmodule : gain_stager

// *** core/input_pga_control_regs.sv ***
// The plain strobed port was decided locally.
`timescale 1ns/1ps
// Control registers for the four input amplifiers
module input_pga_control_regs import pga_regs_pkg::*; #(
    parameter int TIMEOUT_BASE_CYCLES = TIMEOUT_BASE_DEFAULT
) (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic reset_i,
    input wire logic soft_reset_i,
    // Register port
    input reg_req_t req_i,
    output logic [DATA_W-1:0] rd_data_o,
    // Analogue side status
    input wire logic [NUM_AMPS-1:0] zero_cross_i,
    // Timeout clock control
    input wire logic timeout_clock_enable_i,
    input wire logic [TO_DIV_W-1:0] timeout_clock_divider_i,
    // Amplifier controls
    output amp_ctrl_t [NUM_AMPS-1:0] amp_ctrl_o
);

    // Volume register address check, shared by write and read decode
    function automatic logic is_vol(input logic [ADDR_W-1:0] addr);
        is_vol = (addr == OFS_VOL_L1) || (addr == OFS_VOL_L2) ||
                 (addr == OFS_VOL_R1) || (addr == OFS_VOL_R2);
    endfunction : is_vol

    // Amplifier index from a volume address; offsets are consecutive
    function automatic logic [1:0] vol_index(input logic [ADDR_W-1:0] addr);
        vol_index = 2'(addr - OFS_VOL_L1);
    endfunction : vol_index

    // Path of an amplifier: index bit 0 clear is path 1
    function automatic logic amp_path(input int idx);
        amp_path = idx[0];
    endfunction : amp_path

    logic [7:0] pwr_r;
    logic [7:0] pwr_nxt;
    logic [7:0] pin_r;
    logic [7:0] pin_nxt;
    logic [NUM_AMPS-1:0] mute_r;
    logic [NUM_AMPS-1:0] mute_nxt;
    logic [NUM_AMPS-1:0] armed_r;
    logic [NUM_AMPS-1:0] armed_nxt;
    logic [NUM_AMPS-1:0] mute_eff_r;
    logic [NUM_AMPS-1:0] mute_eff_nxt;
    logic [NUM_AMPS-1:0] zc_r;
    logic [NUM_AMPS-1:0] zc_nxt;
    logic [GAIN_W-1:0] staged_r [NUM_AMPS];
    logic [GAIN_W-1:0] staged_nxt [NUM_AMPS];
    logic [DATA_W-1:0] rd_data_r;
    logic [DATA_W-1:0] rd_data_nxt;
    logic [1:0] path_update;
    logic [1:0] wr_idx;
    logic vol_wr;
    logic timeout_tick;
    logic [GAIN_W-1:0] active_gain [NUM_AMPS];
    logic [NUM_AMPS-1:0] gain_pending;

    assign wr_idx = vol_index(req_i.addr);
    assign vol_wr = req_i.wr && !soft_reset_i && is_vol(req_i.addr);

    // Update bit is a write-only strobe, shared by both volume registers of a path
    always_comb begin
        path_update = 2'b00;
        if (vol_wr && req_i.wdata[VU_BIT]) begin
            path_update[wr_idx[0]] = 1'b1;
        end
    end

    // Register file next state; a gain write lands in staging only, mute, zero-cross, power and pin bits apply directly
    always_comb begin
        pwr_nxt = pwr_r;
        pin_nxt = pin_r;
        mute_nxt = mute_r;
        zc_nxt = zc_r;
        // Arm a mute once its bit has been seen low
        armed_nxt = armed_r | ~mute_r;
        for (int i = 0; i < NUM_AMPS; i++) begin
            staged_nxt[i] = staged_r[i];
        end
        if (soft_reset_i) begin
            pwr_nxt = PWR_RESET;
            pin_nxt = PIN_RESET;
            mute_nxt = {NUM_AMPS{MUTE_RESET}};
            armed_nxt = '0;
            zc_nxt = {NUM_AMPS{ZC_RESET}};
            for (int i = 0; i < NUM_AMPS; i++) begin
                staged_nxt[i] = GAIN_RESET;
            end
        end else if (req_i.wr) begin
            if (req_i.addr == OFS_PWR) begin
                pwr_nxt = req_i.wdata[7:0] & PWR_MASK;
            end else if (req_i.addr == OFS_PIN) begin
                pin_nxt = req_i.wdata[7:0];
            end else if (is_vol(req_i.addr)) begin
                mute_nxt[wr_idx] = req_i.wdata[MUTE_BIT];
                zc_nxt[wr_idx] = req_i.wdata[ZC_BIT];
                staged_nxt[wr_idx] = req_i.wdata[GAIN_LSB +: GAIN_W];
            end
        end
        // Reset value reads 1 but stays inactive until armed
        mute_eff_nxt = mute_nxt & armed_nxt;
    end

    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            pwr_r <= PWR_RESET;
            pin_r <= PIN_RESET;
            mute_r <= {NUM_AMPS{MUTE_RESET}};
            armed_r <= '0;
            mute_eff_r <= '0;
            zc_r <= {NUM_AMPS{ZC_RESET}};
            for (int i = 0; i < NUM_AMPS; i++) begin
                staged_r[i] <= GAIN_RESET;
            end
        end else begin
            pwr_r <= pwr_nxt;
            pin_r <= pin_nxt;
            mute_r <= mute_nxt;
            armed_r <= armed_nxt;
            mute_eff_r <= mute_eff_nxt;
            zc_r <= zc_nxt;
            for (int i = 0; i < NUM_AMPS; i++) begin
                staged_r[i] <= staged_nxt[i];
            end
        end
    end

    // Read data valid only in the cycle after the strobe; the update bit reads 0
    always_comb begin
        rd_data_nxt = RD_IDLE;
        if (req_i.rd) begin
            if (req_i.addr == OFS_PWR) begin
                rd_data_nxt = {1'b0, pwr_r};
            end else if (req_i.addr == OFS_PIN) begin
                rd_data_nxt = {1'b0, pin_r};
            end else if (is_vol(req_i.addr)) begin
                rd_data_nxt = RD_IDLE;
                rd_data_nxt[MUTE_BIT] = mute_r[vol_index(req_i.addr)];
                rd_data_nxt[ZC_BIT] = zc_r[vol_index(req_i.addr)];
                rd_data_nxt[GAIN_LSB +: GAIN_W] = staged_r[vol_index(req_i.addr)];
            end
        end
    end

    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            rd_data_r <= RD_IDLE;
        end else begin
            rd_data_r <= rd_data_nxt;
        end
    end

    assign rd_data_o = rd_data_r;

    // Timeout runs free, so the wait after an update is up to one period
    timeout_tick_gen #(
        .BASE_CYCLES(TIMEOUT_BASE_CYCLES)
    ) u_timeout (
        .clk_sys_i(clk_sys_i),
        .reset_i(reset_i),
        .enable_i(timeout_clock_enable_i),
        .divider_i(timeout_clock_divider_i),
        .tick_o(timeout_tick)
    );

    // One stager per amplifier; staged_nxt lets gain and update share one write
    for (genvar g = 0; g < NUM_AMPS; g++) begin : g_amp
        gain_stager u_stager (
            .clk_sys_i(clk_sys_i),
            .reset_i(reset_i),
            .clear_i(soft_reset_i),
            .update_i(path_update[amp_path(g)]),
            .zc_gate_i(zc_nxt[g]),
            .zero_cross_i(zero_cross_i[g]),
            .timeout_i(timeout_tick),
            .staged_i(staged_nxt[g]),
            .active_o(active_gain[g]),
            .pending_o(gain_pending[g])
        );

        // Outputs are flops, pending decoded from the stager state; one gain code serves both amplifier inputs
        assign amp_ctrl_o[g].enable = pwr_r[PWR_BIT[g]];
        assign amp_ctrl_o[g].pos_connect = pin_r[POS_BIT[g]];
        assign amp_ctrl_o[g].neg_connect = pin_r[NEG_BIT[g]];
        assign amp_ctrl_o[g].mute = mute_eff_r[g];
        assign amp_ctrl_o[g].gain_pending = gain_pending[g];
        assign amp_ctrl_o[g].gain = active_gain[g];
    end

    chk_power_enable: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        req_i.wr && !soft_reset_i && req_i.addr == OFS_PWR
        |=> amp_ctrl_o[AMP_L2].enable == $past(req_i.wdata[7]) &&
            amp_ctrl_o[AMP_R1].enable == $past(req_i.wdata[4]))
        else $error("power enable bits not mapped");

    chk_pin_select: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        req_i.wr && !soft_reset_i && req_i.addr == OFS_PIN
        |=> amp_ctrl_o[AMP_L1].pos_connect == $past(req_i.wdata[5]) &&
            amp_ctrl_o[AMP_R2].neg_connect == $past(req_i.wdata[2]))
        else $error("pin select bits not mapped");

    chk_mute_unarmed: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        (armed_r == '0 && !req_i.wr && !soft_reset_i) [*2] |-> amp_ctrl_o[AMP_L1].mute == 1'b0)
        else $error("mute active before being armed");

    chk_mute_toggle: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        vol_wr && wr_idx == 2'b00 && !req_i.wdata[MUTE_BIT]
        ##1 vol_wr && wr_idx == 2'b00 && req_i.wdata[MUTE_BIT]
        |=> amp_ctrl_o[AMP_L1].mute)
        else $error("mute not effective after 0 then 1");

    chk_read_volume: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        req_i.rd && req_i.addr == OFS_VOL_R1
        |=> rd_data_o[VU_BIT] == 1'b0 && rd_data_o[GAIN_LSB +: GAIN_W] == $past(staged_r[AMP_R1]))
        else $error("volume readback wrong");

    chk_read_once: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        !req_i.rd |=> rd_data_o == RD_IDLE)
        else $error("read data outside its cycle");

    chk_pair_update: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        vol_wr && req_i.wdata[VU_BIT] && wr_idx == 2'b00 && !zc_nxt[AMP_R1]
        |=> amp_ctrl_o[AMP_R1].gain == $past(staged_nxt[AMP_R1]))
        else $error("partner gain not updated with path strobe");

    chk_staging_only: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        vol_wr && !req_i.wdata[VU_BIT] && !gain_pending[wr_idx]
        |=> active_gain[$past(wr_idx)] == $past(active_gain[wr_idx]))
        else $error("gain write changed active gain");

endmodule : input_pga_control_regs

// *** core/pga_regs_pkg.sv ***
// Overview of operation
// - Power register bits 7..4 enable left2, left1, right2, right1 amplifiers; reset disabled.
// - Pin select bits 7,5,3,1 pick positive pin (1) or mid-rail (0); reset 0.
// - Pin select bits 6,4,2,0 connect negative pin (1) or leave open (0); reset 0.
// - Each amplifier has its own 5-bit gain, bits 4:0, reset code 01011 (0dB).
// - One gain setting drives both inputs of an amplifier at all times.
// - Volume register bit 7 is each amplifier's own mute: 1 mutes.
// - Mute reads 1 after reset but only mutes after a 0 then 1.
// - Volume bit 6 picks immediate (0) or zero-cross (1) gain change; reset 0.
// - Pending zero-cross gain applies at timeout; timeout clock has enable and divider.
// - Gain writes only stage a value; active gain waits for an update strobe.
// - Path-1 update bit 8 applies left1 and right1 together; path-2 likewise.
// - Left path-2, right path-1, right path-2 volumes follow at the next addresses.
// - Gain code maps linearly: 00000 is -16.5dB, plus 1.5dB per step.
package pga_regs_pkg;

    localparam int ADDR_W = 8;
    localparam int DATA_W = 9;
    localparam int GAIN_W = 5;
    localparam int NUM_AMPS = 4;
    localparam int TO_DIV_W = 2;
    localparam int TO_CNT_W = 24;
    localparam int TIMEOUT_BASE_DEFAULT = 1024;

    // Register offsets
    localparam logic [ADDR_W-1:0] OFS_PWR = 8'h02;
    localparam logic [ADDR_W-1:0] OFS_VOL_L1 = 8'h18;
    localparam logic [ADDR_W-1:0] OFS_VOL_L2 = 8'h19;
    localparam logic [ADDR_W-1:0] OFS_VOL_R1 = 8'h1A;
    localparam logic [ADDR_W-1:0] OFS_VOL_R2 = 8'h1B;
    localparam logic [ADDR_W-1:0] OFS_PIN = 8'h28;

    // Amplifier index order follows the volume registers: left1, left2, right1, right2
    localparam int AMP_L1 = 0;
    localparam int AMP_L2 = 1;
    localparam int AMP_R1 = 2;
    localparam int AMP_R2 = 3;
    localparam int PWR_BIT [NUM_AMPS] = '{6, 7, 4, 5};
    localparam int POS_BIT [NUM_AMPS] = '{5, 7, 1, 3};
    localparam int NEG_BIT [NUM_AMPS] = '{4, 6, 0, 2};

    // Volume register fields
    localparam int VU_BIT = 8;
    localparam int MUTE_BIT = 7;
    localparam int ZC_BIT = 6;
    localparam int GAIN_LSB = 0;

    // Reset values and masks
    localparam logic [7:0] PWR_MASK = 8'hF0;
    localparam logic [7:0] PWR_RESET = 8'h00;
    localparam logic [7:0] PIN_RESET = 8'h00;
    localparam logic [GAIN_W-1:0] GAIN_RESET = 5'h0B;
    localparam logic MUTE_RESET = 1'b1;
    localparam logic ZC_RESET = 1'b0;
    localparam logic [DATA_W-1:0] RD_IDLE = 9'h000;

    // Register port request
    typedef struct packed {
        logic wr;
        logic rd;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } reg_req_t;

    // Per-amplifier control bundle towards the analogue side
    typedef struct packed {
        logic enable;
        logic pos_connect;
        logic neg_connect;
        logic mute;
        logic gain_pending;
        logic [GAIN_W-1:0] gain;
    } amp_ctrl_t;

endpackage : pga_regs_pkg

// *** core/timeout_tick_gen.sv ***
`timescale 1ns/1ps
// Free-running timeout tick for zero-cross gating
module timeout_tick_gen import pga_regs_pkg::*; #(
    parameter int BASE_CYCLES = TIMEOUT_BASE_DEFAULT
) (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic reset_i,
    // Control
    input wire logic enable_i,
    input wire logic [TO_DIV_W-1:0] divider_i,
    // Tick
    output logic tick_o
);

    logic [TO_CNT_W-1:0] cnt_r;
    logic [TO_CNT_W-1:0] cnt_nxt;
    logic tick_r;
    logic tick_nxt;
    logic [TO_CNT_W-1:0] period;

    // Period doubles per divider step
    assign period = TO_CNT_W'(BASE_CYCLES) << divider_i;

    // Counter; disabled clock means no timeout ever fires
    always_comb begin
        cnt_nxt = cnt_r;
        tick_nxt = 1'b0;
        if (!enable_i) begin
            cnt_nxt = '0;
        end else if (cnt_r >= period - TO_CNT_W'(1)) begin
            cnt_nxt = '0;
            tick_nxt = 1'b1;
        end else begin
            cnt_nxt = cnt_r + TO_CNT_W'(1);
        end
    end

    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            cnt_r <= '0;
            tick_r <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            tick_r <= tick_nxt;
        end
    end

    assign tick_o = tick_r;

    chk_tick_single: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        tick_r |-> cnt_r == '0 ##1 !tick_r)
        else $error("timeout tick longer than one cycle");

endmodule : timeout_tick_gen

// *** tb/tb.sv ***
`timescale 1ns/1ps
// Register-level bench for the input amplifier control block
module tb;
    import pga_regs_pkg::*;

    localparam int BASE = 8;

    logic clk_sys_i;
    logic reset_i;
    logic soft_reset_i;
    reg_req_t req_i;
    logic [DATA_W-1:0] rd_data_o;
    logic [NUM_AMPS-1:0] zero_cross_i;
    logic timeout_clock_enable_i;
    logic [TO_DIV_W-1:0] timeout_clock_divider_i;
    amp_ctrl_t [NUM_AMPS-1:0] amp_ctrl_o;
    int errors;
    int tests_run;
    int wait_n;
    // Expected state of each amplifier's controls
    logic exp_en [NUM_AMPS];
    logic exp_pos [NUM_AMPS];
    logic exp_neg [NUM_AMPS];
    logic exp_mute [NUM_AMPS];
    logic exp_pend [NUM_AMPS];
    logic [GAIN_W-1:0] exp_gain [NUM_AMPS];

    // Small timeout base keeps the zero-cross wait short
    input_pga_control_regs #(.TIMEOUT_BASE_CYCLES(BASE)) i_dut (
        .clk_sys_i(clk_sys_i),
        .reset_i(reset_i),
        .soft_reset_i(soft_reset_i),
        .req_i(req_i),
        .rd_data_o(rd_data_o),
        .zero_cross_i(zero_cross_i),
        .timeout_clock_enable_i(timeout_clock_enable_i),
        .timeout_clock_divider_i(timeout_clock_divider_i),
        .amp_ctrl_o(amp_ctrl_o)
    );

    // System clock
    initial begin
        clk_sys_i = 1'b0;
        forever #2.5 clk_sys_i = ~clk_sys_i;
    end

    task automatic close_out;
        $display("tests_run=%0d errors=%0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : close_out

    task automatic chk(input string what, input logic [9:0] exp, input logic [9:0] got);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // One write cycle; gap of one idle cycle before the next request
    task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge clk_sys_i);
        req_i <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge clk_sys_i);
        req_i.wr <= 1'b0;
        #1;
    endtask : wr_reg

    // Two writes on consecutive edges, no idle cycle between them
    task automatic wr_pair(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d0, input logic [DATA_W-1:0] d1);
        @(posedge clk_sys_i);
        req_i <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d0};
        @(posedge clk_sys_i);
        req_i.wdata <= d1;
        @(posedge clk_sys_i);
        req_i.wr <= 1'b0;
        #1;
    endtask : wr_pair

    // Read data stand only in the cycle after the read strobe
    task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
        @(posedge clk_sys_i);
        req_i <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 9'h000};
        @(posedge clk_sys_i);
        req_i.rd <= 1'b0;
        #1;
        chk($sformatf("read %h", a), {1'b0, e}, {1'b0, rd_data_o});
    endtask : rd_chk

    task automatic check_amps;
        for (int i = 0; i < NUM_AMPS; i++) begin
            chk($sformatf("amp%0d", i), {exp_en[i], exp_pos[i], exp_neg[i], exp_mute[i], exp_pend[i], exp_gain[i]},
                amp_ctrl_o[i]);
        end
    endtask : check_amps

    task automatic model_reset;
        for (int i = 0; i < NUM_AMPS; i++) begin
            exp_en[i] = 1'b0;
            exp_pos[i] = 1'b0;
            exp_neg[i] = 1'b0;
            exp_mute[i] = 1'b0;
            exp_pend[i] = 1'b0;
            exp_gain[i] = GAIN_RESET;
        end
    endtask : model_reset

    task automatic reset_reads;
        rd_chk(OFS_PWR, 9'h000);
        rd_chk(OFS_PIN, 9'h000);
        rd_chk(OFS_VOL_L1, 9'h08B);
        rd_chk(OFS_VOL_L2, 9'h08B);
        rd_chk(OFS_VOL_R1, 9'h08B);
        rd_chk(OFS_VOL_R2, 9'h08B);
        check_amps();
    endtask : reset_reads

    // Watchdog: the whole sequence needs well under a thousand cycles
    initial begin
        repeat (5000) @(posedge clk_sys_i);
        errors++;
        $display("BAD watchdog expected done seen hang");
        close_out();
    end

    // Main sequence
    initial begin
        errors = 0;
        tests_run = 0;
        reset_i = 1'b1;
        soft_reset_i = 1'b0;
        req_i = '0;
        zero_cross_i = '0;
        timeout_clock_enable_i = 1'b0;
        timeout_clock_divider_i = '0;
        model_reset();
        repeat (10) @(posedge clk_sys_i);
        reset_i <= 1'b0;
        reset_reads();
        rd_chk(8'h03, 9'h000);
        $display("test reset values done");

        // Power enables, low nibble not kept; right2 stays off as its enable bit 5 is written 0
        wr_reg(OFS_PWR, 9'h0DF);
        rd_chk(OFS_PWR, 9'h0D0);
        for (int i = 0; i < NUM_AMPS; i++) exp_en[i] = PWR_BIT[i] inside {7, 6, 4};
        check_amps();
        // Left2 differential, left1 and right1 single-ended, right2 cleared
        // Reference, bias and mid-rail buffer live outside this block and are set by software
        wr_reg(OFS_PIN, 9'h0D1);
        rd_chk(OFS_PIN, 9'h0D1);
        for (int i = 0; i < NUM_AMPS; i++) begin
            exp_pos[i] = POS_BIT[i] inside {7};
            exp_neg[i] = NEG_BIT[i] inside {6, 4, 0};
        end
        check_amps();
        $display("test enables and pins done");

        // Staged gain, then path-1 update loads left1 and right1 together
        wr_reg(OFS_VOL_L1, 9'h014);
        check_amps();
        rd_chk(OFS_VOL_L1, 9'h014);
        wr_reg(OFS_VOL_R1, 9'h115);
        exp_gain[AMP_L1] = 5'h14;
        exp_gain[AMP_R1] = 5'h15;
        check_amps();
        rd_chk(OFS_VOL_R1, 9'h015);
        // Left1 has held mute 0 since its first write, so a 1 now takes effect
        wr_reg(OFS_VOL_L1, 9'h094);
        exp_mute[AMP_L1] = 1'b1;
        check_amps();
        $display("test staging and mute done");

        // Zero-cross gating on path 2
        wr_reg(OFS_VOL_L2, 9'h04F);
        wr_reg(OFS_VOL_R2, 9'h14A);
        exp_pend[AMP_L2] = 1'b1;
        exp_pend[AMP_R2] = 1'b1;
        check_amps();
        @(posedge clk_sys_i);
        zero_cross_i <= 4'h2;
        @(posedge clk_sys_i);
        zero_cross_i <= 4'h0;
        @(posedge clk_sys_i);
        #1;
        exp_pend[AMP_L2] = 1'b0;
        exp_gain[AMP_L2] = 5'h0F;
        check_amps();
        // Right2 waits for the timeout tick; divider 1 doubles the period
        @(posedge clk_sys_i);
        timeout_clock_enable_i <= 1'b1;
        timeout_clock_divider_i <= 2'h1;
        wait_n = 0;
        while (wait_n < 60 && amp_ctrl_o[AMP_R2].gain_pending !== 1'b0) begin
            @(posedge clk_sys_i);
            #1;
            wait_n++;
        end
        // Period edges until the tick, one more for the stager to load
        chk("timeout wait", 10'((BASE << 1) + 1), 10'(wait_n));
        exp_pend[AMP_R2] = 1'b0;
        exp_gain[AMP_R2] = 5'h0A;
        check_amps();
        $display("test zero cross done");

        // Software reset restores everything
        @(posedge clk_sys_i);
        timeout_clock_enable_i <= 1'b0;
        soft_reset_i <= 1'b1;
        @(posedge clk_sys_i);
        soft_reset_i <= 1'b0;
        @(posedge clk_sys_i);
        #1;
        model_reset();
        reset_reads();
        $display("test soft reset done");

        // After reset a lone 1 leaves mute off; 0 then 1 back to back arms it
        wr_reg(OFS_VOL_L1, 9'h08B);
        check_amps();
        wr_pair(OFS_VOL_L1, 9'h00B, 9'h08B);
        exp_mute[AMP_L1] = 1'b1;
        check_amps();
        $display("test mute arming done");
        close_out();
    end
endmodule : tb
